/* File: core/serial_frame_tx_rx_datapath.sv */
module serial_frame_tx_rx_datapath #(
  parameter int RX_DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire serial_pkg::apb_req_t apb_req,
  output serial_pkg::apb_rsp_t apb_rsp,
  input wire logic rxd_i,
  output logic txd_o,
  output logic txd_oe,
  input wire logic xck_i,
  output logic xck_o,
  output logic xck_oe
);
  import serial_pkg::*;

  // number of data bits for a character size code
  function automatic logic [3:0] bits_of(input logic [2:0] size);
    logic [3:0] n;
    n = 4'h8;
    if (size == SIZE_5) n = 4'h5;
    if (size == SIZE_6) n = 4'h6;
    if (size == SIZE_7) n = 4'h7;
    if (size == SIZE_9L || size == SIZE_9H) n = 4'h9;
    return n;
  endfunction : bits_of

  // mask of the low n bits
  function automatic logic [8:0] mask_of(input logic [3:0] n);
    logic [8:0] m;
    m = 9'h000;
    for (int i = 0; i < 9; i++)
    begin
      if (4'(i) < n) m[i] = 1'b1;
    end
    return m;
  endfunction : mask_of

  // parity bit over the low n bits
  function automatic logic parity_of(input logic [8:0] d, input logic [3:0] n, input logic odd);
    logic p;
    p = odd;
    for (int i = 0; i < 9; i++)
    begin
      if (4'(i) < n) p = p ^ d[i];
    end
    return p;
  endfunction : parity_of

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: only the second stage is read by logic

  logic [1:0] rxd_sync_q;
  logic [1:0] xck_sync_q;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rxd_sync_q <= 2'h3;
      xck_sync_q <= 2'h0;
    end
    else
    begin
      rxd_sync_q <= {rxd_sync_q[0], rxd_i};
      xck_sync_q <= {xck_sync_q[0], xck_i};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers and field decode

  logic [7:0] ctrl_b_q;
  logic [7:0] ctrl_c_q;
  logic [15:0] baud_q;
  logic tx_high_q;
  logic rx_line;
  logic rx_en;
  logic tx_en_req;
  logic [1:0] rx_mode;
  logic sync_mode;
  logic master;
  logic [2:0] size_code;
  logic two_stop;
  logic par_en;
  logic par_odd;
  logic nine_bit_low_first;
  logic [3:0] nbits;
  logic [4:0] spb;

  assign rx_line = rxd_sync_q[1];
  assign rx_en = ctrl_b_q[CB_RXEN];
  assign tx_en_req = ctrl_b_q[CB_TXEN];
  assign rx_mode = ctrl_b_q[CB_MODE +: 2];
  assign sync_mode = ctrl_c_q[CC_SYNC];
  assign master = ctrl_c_q[CC_MASTER];
  assign size_code = ctrl_c_q[CC_SIZE +: 3];
  assign two_stop = ctrl_c_q[CC_STOP2];
  assign par_en = ctrl_c_q[CC_PAR +: 2] == PAR_EVEN || ctrl_c_q[CC_PAR +: 2] == PAR_ODD;
  assign par_odd = ctrl_c_q[CC_PAR +: 2] == PAR_ODD;
  assign nine_bit_low_first = size_code == SIZE_9L;
  assign nbits = bits_of(size_code);
  // in async, modes 0, 2 and 3 all sample at normal speed; only mode 1 doubles; sync always uses SPB_SYNC
  assign spb = sync_mode ? SPB_SYNC : (rx_mode == MODE_DOUBLE ? SPB_DOUBLE : SPB_NORMAL);

  //////////////////////////////////////////////////////////////////////////////
  // apb decode: answer is registered, so every access has one wait-free cycle

  logic setup_ph;
  logic access_ph;
  logic wr_stb;
  logic rd_stb;
  logic hit_rxl;
  logic hit_rxh;
  logic hit_txl;
  logic hit_txh;
  logic hit_st;
  logic hit_cb;
  logic hit_cc;
  logic hit_bd;
  logic mapped;
  logic [31:0] rd_mux;

  assign setup_ph = apb_req.psel & ~apb_req.penable;
  assign access_ph = apb_req.psel & apb_req.penable & apb_rsp.pready;
  assign wr_stb = access_ph & apb_req.pwrite;
  assign rd_stb = access_ph & ~apb_req.pwrite;
  assign hit_rxl = apb_req.paddr == OFS_RX_LOW;
  assign hit_rxh = apb_req.paddr == OFS_RX_HIGH;
  assign hit_txl = apb_req.paddr == OFS_TX_LOW;
  assign hit_txh = apb_req.paddr == OFS_TX_HIGH;
  assign hit_st = apb_req.paddr == OFS_STATUS;
  assign hit_cb = apb_req.paddr == OFS_CTRL_B;
  assign hit_cc = apb_req.paddr == OFS_CTRL_C;
  assign hit_bd = apb_req.paddr == OFS_BAUD;
  assign mapped = hit_rxl | hit_rxh | hit_txl | hit_txh | hit_st | hit_cb | hit_cc | hit_bd;

  // response flop: data sampled in setup, shown during access
  always_ff @(posedge clk)
  begin
    if (rst) apb_rsp <= '0;
    else
    begin
      apb_rsp.pready <= setup_ph;
      apb_rsp.pslverr <= setup_ph & ~mapped;
      apb_rsp.prdata <= setup_ph & ~apb_req.pwrite ? rd_mux : 32'h0000_0000;
    end
  end

  // control registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrl_b_q <= CTRL_B_RST;
      ctrl_c_q <= CTRL_C_RST;
      baud_q <= BAUD_RST;
      tx_high_q <= 1'b0;
    end
    else if (wr_stb)
    begin
      if (hit_cb) ctrl_b_q <= apb_req.pwdata[7:0];
      if (hit_cc) ctrl_c_q <= apb_req.pwdata[7:0];
      if (hit_bd) baud_q <= apb_req.pwdata[15:0];
      if (hit_txh) tx_high_q <= apb_req.pwdata[0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sample tick divider and transfer clock

  logic [15:0] baud_cnt_q;
  logic tick;
  logic xck_q;
  logic xck_prev_q;
  logic xck_src;
  logic xck_rise;
  logic xck_fall;

  // baud_q of zero behaves as one rather than stalling
  assign tick = {1'b0, baud_cnt_q} + 17'h00001 >= {1'b0, baud_q};
  assign xck_src = master ? xck_q : xck_sync_q[1];
  assign xck_rise = xck_src & ~xck_prev_q;
  assign xck_fall = ~xck_src & xck_prev_q;

  // master toggles its own clock at the sample rate: two samples make one bit
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      baud_cnt_q <= 16'h0000;
      xck_q <= 1'b0;
      xck_prev_q <= 1'b0;
      xck_oe <= 1'b0;
    end
    else
    begin
      baud_cnt_q <= tick ? 16'h0000 : baud_cnt_q + 16'h0001;
      if (tick & sync_mode & master) xck_q <= ~xck_q;
      xck_prev_q <= xck_src;
      xck_oe <= sync_mode & master;
    end
  end
  assign xck_o = xck_q;

  //////////////////////////////////////////////////////////////////////////////
  // transmitter: one-word buffer in front of the shift register

  tx_state_t tx_state_q;
  logic [4:0] tx_ph_q;
  logic tx_bit;
  logic [8:0] tx_buf_q;
  logic tx_buf_full_q;
  logic [8:0] tx_shift_q;
  logic [3:0] tx_idx_q;
  logic tx_par_q;
  logic tx_on_q;
  logic txc_q;
  logic tx_last;
  logic tx_load;
  logic tx_write;

  assign tx_bit = sync_mode ? xck_rise : tick & tx_ph_q >= spb - 5'h01;
  assign tx_last = tx_bit & (tx_state_q == TX_STOP2 | (tx_state_q == TX_STOP1 & ~two_stop));
  assign tx_load = tx_bit & tx_buf_full_q & tx_on_q & (tx_state_q == TX_IDLE | tx_last);
  // a write into a full buffer is dropped; software must wait for empty
  assign tx_write = wr_stb & hit_txl & ~tx_buf_full_q;

  // buffer, enable and complete flag
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      tx_buf_q <= 9'h000;
      tx_buf_full_q <= 1'b0;
      tx_on_q <= 1'b0;
      txc_q <= 1'b0;
      txd_oe <= 1'b0;
      tx_ph_q <= 5'h00;
    end
    else
    begin
      if (tx_write) tx_buf_q <= {tx_high_q, apb_req.pwdata[7:0]} & mask_of(nbits);
      if (tx_write) tx_buf_full_q <= 1'b1;
      else if (tx_load) tx_buf_full_q <= 1'b0;
      if (tx_en_req) tx_on_q <= 1'b1;
      else if (tx_state_q == TX_IDLE & ~tx_buf_full_q) tx_on_q <= 1'b0;
      // set wins over a write-one clear in the same cycle
      if (tx_last & ~tx_buf_full_q) txc_q <= 1'b1;
      else if (wr_stb & hit_st & apb_req.pwdata[ST_TXC]) txc_q <= 1'b0;
      txd_oe <= tx_on_q;
      if (tick) tx_ph_q <= tx_ph_q >= spb - 5'h01 ? 5'h00 : tx_ph_q + 5'h01;
    end
  end

  // frame sequencer
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      tx_state_q <= TX_IDLE;
      tx_shift_q <= 9'h000;
      tx_idx_q <= 4'h0;
      tx_par_q <= 1'b0;
    end
    else if (tx_load)
    begin
      tx_state_q <= TX_START;
      tx_shift_q <= tx_buf_q;
      tx_idx_q <= 4'h0;
      tx_par_q <= parity_of(tx_buf_q, nbits, par_odd);
    end
    else if (tx_bit)
    begin
      case (tx_state_q)
        TX_START: tx_state_q <= TX_DATA;
        TX_DATA:
        begin
          tx_shift_q <= tx_shift_q >> 1;
          tx_idx_q <= tx_idx_q + 4'h1;
          if (tx_idx_q == nbits - 4'h1) tx_state_q <= par_en ? TX_PAR : TX_STOP1;
        end
        TX_PAR: tx_state_q <= TX_STOP1;
        TX_STOP1: tx_state_q <= two_stop ? TX_STOP2 : TX_IDLE;
        TX_STOP2: tx_state_q <= TX_IDLE;
        default: tx_state_q <= TX_IDLE;
      endcase
    end
  end

  // line level; idle line is high
  always_ff @(posedge clk)
  begin
    if (rst) txd_o <= 1'b1;
    else
    begin
      case (tx_state_q)
        TX_START: txd_o <= 1'b0;
        TX_DATA: txd_o <= tx_shift_q[0];
        TX_PAR: txd_o <= tx_par_q;
        default: txd_o <= 1'b1;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // receiver: shift register feeding a small buffer

  rx_state_t rx_state_q;
  logic [4:0] rx_ph_q;
  logic rx_smp;
  logic [8:0] rx_shift_q;
  logic [3:0] rx_idx_q;
  logic rx_par_q;
  logic rx_armed_q;
  logic rx_start_ok;
  logic rx_done;
  logic rx_pop;
  rx_entry_t rx_new;
  rx_entry_t rx_mem_q [RX_DEPTH];
  logic [2:0] rx_fill_q;
  logic [2:0] fill_after_pop;
  logic [2:0] wr_idx;
  logic rx_full;
  logic rxc;

  // async: mid-bit sample every spb ticks; sync: falling transfer clock edge
  assign rx_smp = sync_mode ? xck_fall : tick & rx_ph_q >= spb - 5'h01;
  assign rx_done = rx_smp & rx_state_q == RX_STOP;
  // a start needs a high line first, so a low stop bit is never taken as a new start
  assign rx_start_ok = rx_armed_q & ~rx_line;
  assign rxc = rx_fill_q != 3'h0;
  assign rx_full = rx_fill_q == 3'(RX_DEPTH);
  // the register that advances depends on the nine-bit ordering
  assign rx_pop = rd_stb & rxc & (nine_bit_low_first ? hit_rxh : hit_rxl);
  assign fill_after_pop = rx_pop ? rx_fill_q - 3'h1 : rx_fill_q;
  assign wr_idx = fill_after_pop == 3'(RX_DEPTH) ? 3'(RX_DEPTH - 1) : fill_after_pop;
  assign rx_new.data = rx_shift_q;
  assign rx_new.parity_error_flag = par_en & (parity_of(rx_shift_q, nbits, par_odd) != rx_par_q);
  assign rx_new.frame_error_flag = ~rx_line;
  assign rx_new.ovf = fill_after_pop == 3'(RX_DEPTH);

  // frame sequencer; disable drops a frame in progress at once
  always_ff @(posedge clk)
  begin
    if (rst | ~rx_en)
    begin
      rx_state_q <= RX_IDLE;
      rx_ph_q <= 5'h00;
      rx_shift_q <= 9'h000;
      rx_idx_q <= 4'h0;
      rx_par_q <= 1'b0;
      rx_armed_q <= 1'b0;
    end
    else
    begin
      if (tick) rx_ph_q <= rx_ph_q >= spb - 5'h01 ? 5'h00 : rx_ph_q + 5'h01;
      case (rx_state_q)
        RX_IDLE:
        begin
          rx_idx_q <= 4'h0;
          rx_shift_q <= 9'h000;
          if (rx_line) rx_armed_q <= 1'b1;
          if (sync_mode & xck_fall & rx_start_ok)
          begin
            rx_state_q <= RX_DATA;
            rx_armed_q <= 1'b0;
          end
          else if (~sync_mode & tick & rx_start_ok)
          begin
            rx_state_q <= RX_START;
            rx_ph_q <= 5'h01;
            rx_armed_q <= 1'b0;
          end
        end
        RX_START:
          // recheck at mid start bit; a high line was noise
          if (tick & rx_ph_q >= (spb >> 1) - 5'h01)
          begin
            rx_state_q <= rx_line ? RX_IDLE : RX_DATA;
            rx_ph_q <= 5'h00;
          end
        RX_DATA:
          if (rx_smp)
          begin
            rx_shift_q[rx_idx_q] <= rx_line;
            rx_idx_q <= rx_idx_q + 4'h1;
            if (rx_idx_q == nbits - 4'h1) rx_state_q <= par_en ? RX_PAR : RX_STOP;
          end
        RX_PAR:
          if (rx_smp)
          begin
            rx_par_q <= rx_line;
            rx_state_q <= RX_STOP;
          end
        // only the first stop is checked; a second reads as idle high
        RX_STOP: if (rx_smp) rx_state_q <= RX_IDLE;
        default: rx_state_q <= RX_IDLE;
      endcase
    end
  end

  // fill count of the buffer
  always_ff @(posedge clk)
  begin
    if (rst | ~rx_en) rx_fill_q <= 3'h0;
    else if (rx_done & ~rx_new.ovf) rx_fill_q <= fill_after_pop + 3'h1;
    else rx_fill_q <= fill_after_pop;
  end

  // buffer entries: pop shifts toward entry 0, push writes the first free slot, or overwrites the top entry when the buffer is full
  for (genvar i = 0; i < RX_DEPTH; i++)
  begin : g_rx_entry
    always_ff @(posedge clk)
    begin
      if (rst) rx_mem_q[i] <= '0;
      else if (rx_done & wr_idx == 3'(i)) rx_mem_q[i] <= rx_new;
      // the vacated top entry is cleared so an empty buffer shows no stale flags unless a disable left entries behind
      else if (rx_pop) rx_mem_q[i] <= i < RX_DEPTH - 1 ? rx_mem_q[(i + 1) % RX_DEPTH] : '0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read data selection

  logic [7:0] rx_high_word;
  logic [7:0] status_word;

  assign rx_high_word = {rxc, rx_mem_q[0].ovf, 3'h0, rx_mem_q[0].frame_error_flag, rx_mem_q[0].parity_error_flag,
                         rx_mem_q[0].data[8]};
  assign status_word = {rxc, txc_q, ~tx_buf_full_q, 5'h00};
  assign rd_mux = hit_rxl ? {24'h000000, rx_mem_q[0].data[7:0]} :
                  hit_rxh ? {24'h000000, rx_high_word} :
                  hit_st ? {24'h000000, status_word} :
                  hit_cb ? {24'h000000, ctrl_b_q} :
                  hit_cc ? {24'h000000, ctrl_c_q} :
                  hit_bd ? {16'h0000, baud_q} : 32'h0000_0000;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_tx_buffer_load: assert property (tx_load |=> tx_state_q == TX_START && !tx_buf_full_q)
    else $error("buffered word did not move into the shifter");
  a_tx_complete_set: assert property (tx_last && !tx_buf_full_q |=> txc_q)
    else $error("transmit complete not set after last stop");
  a_tx_disable_waits: assert property (
    tx_on_q && !tx_en_req && (tx_state_q != TX_IDLE || tx_buf_full_q) |=> tx_on_q)
    else $error("transmitter dropped with data pending");
  a_tx_pin_release: assert property (!tx_on_q ##1 !tx_on_q |-> !txd_oe)
    else $error("pin still driven after disable");
  a_tx_start_low: assert property (tx_state_q == TX_START ##1 tx_state_q == TX_START |-> !txd_o)
    else $error("start bit not low");
  a_rx_push_flag: assert property (rx_done && rx_en |=> rx_fill_q != 3'h0)
    else $error("receive complete not set after stop");
  a_rx_overflow: assert property (
    rx_done && rx_en && rx_full && !rx_pop |=> rx_mem_q[RX_DEPTH - 1].ovf && rx_full)
    else $error("overflow not flagged");
  a_rx_flush: assert property (!rx_en |=> rx_fill_q == 3'h0 && rx_state_q == RX_IDLE)
    else $error("receiver disable did not flush");
  a_rx_upper_zero: assert property (
    rx_done |-> (rx_shift_q & ~mask_of(nbits)) == 9'h000)
    else $error("unused received bits not zero");
  a_rx_read_pop: assert property (
    rd_stb && hit_rxl && !nine_bit_low_first && rx_fill_q == 3'h1 && !rx_done |=> !rxc)
    else $error("low byte read did not advance buffer");
  a_rx_spb_async: assert property (
    !sync_mode && rx_state_q == RX_DATA && rx_smp |-> rx_ph_q == spb - 5'h01)
    else $error("sample spacing broken");

  c_tx_back_to_back: cover property (tx_last && tx_load);
  c_rx_overflow: cover property (rx_done && rx_new.ovf);
  c_rx_frame_error: cover property (rx_done && rx_new.frame_error_flag);
  c_sync_slave_rx: cover property (rx_done && sync_mode && !master);
endmodule : serial_frame_tx_rx_datapath

/* File: shared/serial_pkg.sv */
package serial_pkg;
  // register byte offsets on the apb side
  localparam logic [7:0] OFS_RX_LOW = 8'h00;
  localparam logic [7:0] OFS_RX_HIGH = 8'h04;
  localparam logic [7:0] OFS_TX_LOW = 8'h08;
  localparam logic [7:0] OFS_TX_HIGH = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_CTRL_B = 8'h14;
  localparam logic [7:0] OFS_CTRL_C = 8'h18;
  localparam logic [7:0] OFS_BAUD = 8'h1C;
  // receive_high_and_errors fields
  localparam int RH_DATA8 = 0;
  localparam int RH_PARITY_ERROR_FLAG = 1;
  localparam int RH_FRAME_ERROR_FLAG = 2;
  localparam int RH_OVF = 6;
  localparam int RH_RXC = 7;
  // status fields
  localparam int ST_DRE = 5;
  localparam int ST_TXC = 6;
  localparam int ST_RXC = 7;
  // control b fields
  localparam int CB_RXEN = 0;
  localparam int CB_TXEN = 1;
  localparam int CB_MODE = 2;
  // control c fields
  localparam int CC_SIZE = 0;
  localparam int CC_STOP2 = 3;
  localparam int CC_PAR = 4;
  localparam int CC_SYNC = 6;
  localparam int CC_MASTER = 7;
  // encodings
  localparam logic [1:0] PAR_EVEN = 2'h2;
  localparam logic [1:0] PAR_ODD = 2'h3;
  localparam logic [1:0] MODE_DOUBLE = 2'h1;
  localparam logic [2:0] SIZE_5 = 3'h0;
  localparam logic [2:0] SIZE_6 = 3'h1;
  localparam logic [2:0] SIZE_7 = 3'h2;
  localparam logic [2:0] SIZE_9L = 3'h6;
  localparam logic [2:0] SIZE_9H = 3'h7;
  // samples per bit
  localparam logic [4:0] SPB_NORMAL = 5'h10;
  localparam logic [4:0] SPB_DOUBLE = 5'h08;
  localparam logic [4:0] SPB_SYNC = 5'h02;
  // reset values
  localparam logic [7:0] CTRL_B_RST = 8'h00;
  localparam logic [7:0] CTRL_C_RST = 8'h03;
  localparam logic [15:0] BAUD_RST = 16'h0001;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic ovf;
    logic frame_error_flag;
    logic parity_error_flag;
    logic [8:0] data;
  } rx_entry_t;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP1, TX_STOP2} tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_t;
endpackage : serial_pkg

/* File: test/serial_remote_node.sv */
module serial_remote_node (
  input wire logic clk,
  input wire logic txd,
  output logic rxd,
  output logic transfer_clock_pin
);
  timeunit 1ns;
  timeprecision 1ns;

  // line idles high and the clock stands still between frames
  initial
  begin
    rxd = 1'b1;
    transfer_clock_pin = 1'b0;
  end

  // lsb first, c clocks a bit; as clock master xck rises as each bit starts
  task automatic send(input logic [12:0] f, input int n, input int c, input bit s);
    for (int i = 0; i < n; i++)
    begin
      rxd <= f[i];
      transfer_clock_pin <= s;
      repeat (c / 2) @(posedge clk);
      transfer_clock_pin <= 1'b0;
      repeat (c / 2) @(posedge clk);
    end
    // one idle clock keeps back-to-back calls from driving rxd twice in a step
    rxd <= 1'b1;
    @(posedge clk);
  endtask : send

  // samples mid-bit at 16 clocks a bit; returns at the last bit's middle
  task automatic grab(input int n, output logic [12:0] f);
    int t;
    f = '1;
    t = 0;
    while (txd !== 1'b0 && t < 5000)
    begin
      @(posedge clk);
      t++;
    end
    repeat (8) @(posedge clk);
    for (int i = 0; i < n; i++)
    begin
      f[i] = txd;
      if (i < n - 1)
        repeat (16) @(posedge clk);
    end
  endtask : grab
endmodule : serial_remote_node

/* File: test/serial_frame_tx_rx_datapath_bench.sv */
module serial_frame_tx_rx_datapath_bench;
  import serial_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk, rst, txd_o, txd_oe, xck_o, xck_oe, rxd_p, xck_p, err;
  apb_req_t req;
  apb_rsp_t rsp;
  logic [31:0] rd;
  logic [12:0] fa, fb;
  int num_errors, comparisons;
  // pins resolve to the pull-up or the partner when the block lets go
  wire logic txd_w = (txd_oe === 1'b1) ? txd_o : 1'b1;
  wire logic xck_w = (xck_oe === 1'b1) ? xck_o : xck_p;

  serial_frame_tx_rx_datapath i_serial_frame_tx_rx_datapath (.clk(clk), .rst(rst),
    .apb_req(req), .apb_rsp(rsp), .rxd_i(rxd_p), .txd_o(txd_o), .txd_oe(txd_oe),
    .xck_i(xck_w), .xck_o(xck_o), .xck_oe(xck_oe));
  serial_remote_node i_serial_remote_node (.clk(clk), .txd(txd_w), .rxd(rxd_p),
    .transfer_clock_pin(xck_p));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  ////////////////////////////////////////
  task automatic print_verdict;
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict

  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      num_errors++;
      $display("Error %s expected %0h seen %0h", n, e, s);
    end
  endtask : check

  // request held from setup until pready is seen high at a rising edge; data taken there
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    t = 0;
    do
    begin
      @(posedge clk);
      t++;
    end while (rsp.pready !== 1'b1 && t < 20);
    check("pready", rsp.pready, 1'b1);
    if (rsp.pready !== 1'b1)
      print_verdict();
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    @(posedge clk);
  endtask : apb

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check($sformatf("reg %0h", a), rd, e);
  endtask : rchk

  task automatic poll(input logic [7:0] a, input int b);
    int t;
    t = 0;
    do
    begin
      apb(1'b0, a, 32'h0);
      t++;
    end while (rd[b] !== 1'b1 && t < 300);
    check("flag", rd[b], 1'b1);
    if (rd[b] !== 1'b1)
      print_verdict();
  endtask : poll

  // start, lsb-first data, optional parity, then stop ones
  function automatic logic [12:0] fbits(input logic [8:0] d, input int nb, input logic [1:0] p);
    logic [12:0] f;
    logic q;
    f = '1;
    f[0] = 1'b0;
    q = p[0];
    for (int i = 0; i < nb; i++)
    begin
      f[i + 1] = d[i];
      q = q ^ d[i];
    end
    if (p[1])
      f[nb + 1] = q;
    return f;
  endfunction : fbits

  task automatic txchk(input logic [12:0] e, input int n);
    i_serial_remote_node.grab(n, fb);
    check("tx frame", fb, e);
    poll(OFS_STATUS, ST_TXC);
    apb(1'b1, OFS_STATUS, 32'h40);
  endtask : txchk

  task automatic rx(input logic [12:0] f, input int n, input int c, input bit s);
    i_serial_remote_node.send(f, n, c, s);
  endtask : rx

  ////////////////////////////////////////
  initial
  begin
    req = '0;
    rst = 1'b1;
    num_errors = 0;
    comparisons = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // reset values and an unmapped place
    rchk(OFS_CTRL_C, 32'h03);
    rchk(OFS_BAUD, 32'h01);
    rchk(OFS_STATUS, 32'h20);
    apb(1'b0, 8'h20, 32'h0);
    check("slverr", err, 1'b1);
    check("oe idle", txd_oe, 1'b0);
    // transmit: byte, short word with parity, nine bits high part first
    apb(1'b1, OFS_CTRL_B, 32'h2);
    apb(1'b1, OFS_TX_LOW, 32'hA5);
    txchk(fbits(9'h0A5, 8, 2'h0), 10);
    apb(1'b1, OFS_CTRL_C, 32'h20);
    apb(1'b1, OFS_TX_LOW, 32'hF5);
    txchk(fbits(9'h015, 5, PAR_EVEN), 8);
    apb(1'b1, OFS_CTRL_C, 32'h07);
    apb(1'b1, OFS_TX_HIGH, 32'h1);
    apb(1'b1, OFS_TX_LOW, 32'h3C);
    txchk(fbits(9'h13C, 9, 2'h0), 11);
    // two words queued, then a disable that must wait for both
    apb(1'b1, OFS_CTRL_C, 32'h03);
    fork
      begin
        i_serial_remote_node.grab(10, fa);
        i_serial_remote_node.grab(10, fb);
      end
      begin
        apb(1'b1, OFS_TX_LOW, 32'h11);
        poll(OFS_STATUS, ST_DRE);
        apb(1'b1, OFS_TX_LOW, 32'h22);
        apb(1'b1, OFS_CTRL_B, 32'h0);
        check("oe held", txd_oe, 1'b1);
      end
    join
    check("tx first", fa, fbits(9'h011, 8, 2'h0));
    check("tx second", fb, fbits(9'h022, 8, 2'h0));
    for (int t = 0; t < 20 && txd_oe !== 1'b0; t++)
      @(posedge clk);
    check("oe off", txd_oe, 1'b0);
    // receive: byte, parity and frame errors, then overflow
    apb(1'b1, OFS_CTRL_B, 32'h1);
    rx(fbits(9'h05A, 8, 2'h0), 10, 16, 1'b0);
    rchk(OFS_RX_HIGH, 32'h80);
    rchk(OFS_RX_LOW, 32'h5A);
    rchk(OFS_RX_HIGH, 32'h00);
    apb(1'b1, OFS_CTRL_C, 32'h23);
    rx(fbits(9'h00F, 8, PAR_EVEN) ^ 13'h0200, 11, 16, 1'b0);
    rx(fbits(9'h033, 8, PAR_EVEN) & 13'h1BFF, 11, 16, 1'b0);
    rchk(OFS_RX_HIGH, 32'h82);
    rchk(OFS_RX_LOW, 32'h0F);
    rchk(OFS_RX_HIGH, 32'h84);
    rchk(OFS_RX_LOW, 32'h33);
    for (int i = 1; i < 4; i++)
      rx(fbits(9'(i), 8, PAR_EVEN), 11, 16, 1'b0);
    rchk(OFS_RX_HIGH, 32'h80);
    rchk(OFS_RX_LOW, 32'h01);
    rchk(OFS_RX_HIGH, 32'hC0);
    rchk(OFS_RX_LOW, 32'h03);
    // five bits with two stops; the second stop is not data
    apb(1'b1, OFS_CTRL_C, 32'h08);
    rx(fbits(9'h1F5, 5, 2'h0), 8, 16, 1'b0);
    rchk(OFS_RX_HIGH, 32'h80);
    rchk(OFS_RX_LOW, 32'h15);
    // nine bits low first: the high read advances
    apb(1'b1, OFS_CTRL_C, 32'h06);
    rx(fbits(9'h1A5, 9, 2'h0), 11, 16, 1'b0);
    rchk(OFS_RX_LOW, 32'hA5);
    rchk(OFS_RX_HIGH, 32'h81);
    rchk(OFS_RX_HIGH, 32'h00);
    // double speed, a flush by reading, then a disable that flushes
    apb(1'b1, OFS_CTRL_C, 32'h03);
    apb(1'b1, OFS_CTRL_B, 32'h5);
    rx(fbits(9'h096, 8, 2'h0), 10, 8, 1'b0);
    rchk(OFS_RX_HIGH, 32'h80);
    rchk(OFS_RX_LOW, 32'h96);
    rx(fbits(9'h0E1, 8, 2'h0), 10, 8, 1'b0);
    rd = 32'h80;
    for (int t = 0; t < 4 && rd[RH_RXC] === 1'b1; t++)
    begin
      apb(1'b0, OFS_RX_HIGH, 32'h0);
      if (rd[RH_RXC] === 1'b1)
        apb(1'b0, OFS_RX_LOW, 32'h0);
    end
    check("flushed", rd[RH_RXC], 1'b0);
    rx(fbits(9'h077, 8, 2'h0), 10, 8, 1'b0);
    apb(1'b1, OFS_CTRL_B, 32'h0);
    apb(1'b1, OFS_CTRL_B, 32'h1);
    rchk(OFS_RX_HIGH, 32'h00);
    // clocked slave on an 800 ns transfer clock, then master drives it
    apb(1'b1, OFS_CTRL_C, 32'h43);
    check("clk free", xck_oe, 1'b0);
    rx(fbits(9'h0C3, 8, 2'h0), 10, 8, 1'b1);
    rchk(OFS_RX_HIGH, 32'h80);
    rchk(OFS_RX_LOW, 32'hC3);
    apb(1'b1, OFS_CTRL_C, 32'hC3);
    // the enable is registered one clock after the control write lands
    @(posedge clk);
    check("clk drive", xck_oe, 1'b1);
    fa[0] = xck_o;
    @(posedge clk);
    check("clk toggle", xck_o ^ fa[0], 1'b1);
    print_verdict();
  end
endmodule : serial_frame_tx_rx_datapath_bench
